//--- rtl/ldir_regs.svh
// configuration indices, device numbers and decode constants
// Behaviour
// R1: floppy base 100h-ff8h, 8-aligned, seven offsets
// R2: parallel base 4-aligned; EPP needs 8-aligned
// R3: parallel extended registers at base+400h..402h
// R4: keyboard fixed at 60h and 64h
// R5: decode uses address bits 11..0 only
// R6: level low nibble picks irq, zero none
// R7: irqs active high, parallel enhanced modes inverted
// R8: floppy irq needs level and dma enable
// R9: parallel irq needs enable, service mask clear in ecp modes
// R10: serial irq needs uart enable, aux two
// R11: unclaimed irq lines stay released
// R12: base high at 60h, low at 61h
// R13: activate is one bit, taken from bit 0 of the written data
// R14: out-of-range base ignores host accesses
// R15: host enters configuration state before access
// R16: claimed line follows request, drops one cycle after claim lapses
`ifndef LDIR_REGS_SVH
`define LDIR_REGS_SVH
`define LDIR_IDX_ACT 8'h30
`define LDIR_IDX_BASE_HI 8'h60
`define LDIR_IDX_BASE_LO 8'h61
`define LDIR_IDX_IRQ 8'h70
`define LDIR_LDN_FLOPPY 8'h00
`define LDIR_LDN_PAR 8'h03
`define LDIR_LDN_SER1 8'h04
`define LDIR_LDN_SER2 8'h05
`define LDIR_LDN_KEYB 8'h07
`define LDIR_NDEV 5
`define LDIR_DEV_FLOPPY 0
`define LDIR_DEV_PAR 1
`define LDIR_DEV_SER1 2
`define LDIR_DEV_SER2 3
`define LDIR_DEV_KEYB 4
`define LDIR_BASE_MIN 16'h0100
`define LDIR_BASE_MAX8 16'h0ff8
`define LDIR_BASE_MAX4 16'h0ffc
`define LDIR_FLOPPY_HOLE 3'h6
`define LDIR_PAR_STD_END 2'h3
`define LDIR_EPP_FIRST 3'h3
`define LDIR_EXT_OFS 12'h400
`define LDIR_EXT_LAST 2'h2
`define LDIR_KEYB_DATA 12'h060
`define LDIR_KEYB_CMD 12'h064
`define LDIR_LVL_NONE 4'h0
`define LDIR_ECR_FIFO 3'h2
`define LDIR_ECR_ECP 3'h3
`define LDIR_ECR_EPP 3'h4
`define LDIR_ECR_TEST 3'h6
`endif

//--- rtl/ldir_pkg.sv
// shared types for the logical device decode and irq steering
package ldir_pkg;
  typedef struct packed {
    logic floppy_cs;
    logic [2:0] floppy_ofs;
    logic par_cs;
    logic [2:0] par_ofs;
    logic par_ext_cs;
    logic [1:0] par_ext_ofs;
    logic [1:0] ser_cs;
    logic [2:0] ser_ofs;
    logic keyb_cs;
    logic keyb_cmd;
    logic rd;
    logic wr;
  } ldir_sel_t;

  typedef struct packed {
    logic floppy_dma_irq_enable;
    logic port_interrupt_enable;
    logic service_interrupt_mask;
    logic [2:0] ecr_mode;
    logic [3:0] uart_ier0;
    logic [3:0] uart_ier1;
    logic [1:0] aux_output_two;
  } ldir_unit_t;
endpackage

//--- rtl/ldir_irq_route.sv
// steers device interrupt requests onto the fifteen irq lines
`timescale 1ns/100ps
module ldir_irq_route (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [19:0] lvl_i,
  input wire logic [4:0] en_i,
  input wire logic [4:0] req_i,
  output logic [15:1] line_o,
  output logic [15:1] oe_o
);
  logic [15:1] line_nxt;
  logic [15:1] oe_nxt;
  genvar gn;
  genvar gd;
  generate
    for (gn = 1; gn < 16; gn++) begin : g_line
      wire [4:0] claim;
      for (gd = 0; gd < 5; gd++) begin : g_dev
        assign claim[gd] = en_i[gd] && (lvl_i[4*gd +: 4] == 4'(gn)); // R6
      end
      assign oe_nxt[gn] = |claim; // R11
      assign line_nxt[gn] = |(claim & req_i); // R16
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_o <= '0;
      oe_o <= '0;
    end else begin
      line_o <= line_nxt;
      oe_o <= oe_nxt;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_idle_lines_float: assert property (en_i == 5'h00 |=> oe_o == 15'h0000) // R11
    else $error("irq line driven with no enabled device");
  a_zero_level_none: assert property (lvl_i == 20'h00000 |=> oe_o == 15'h0000) // R6
    else $error("irq line driven with all levels zero");
  a_drive_follows_req: assert property (
    en_i[0] && lvl_i[3:0] == 4'h6 && req_i[0] |=> line_o[6] && oe_o[6]) // R16
    else $error("claimed line does not follow request");
  a_release_on_lapse: assert property (
    oe_o[6] && !en_i[0] && lvl_i[19:4] == 16'h0000 |=> !oe_o[6]) // R16
    else $error("line not released when enable lapsed");
  c_line_driven: cover property (oe_o[7] && line_o[7]);
endmodule

//--- rtl/ldir_top.sv
// logical device configuration registers, i/o decode and irq routing
`timescale 1ns/100ps
`include "ldir_regs.svh"
module ldir_top (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic cfg_mode_i,
  input wire logic [7:0] ldn_i,
  input wire logic [7:0] cfg_index_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  output logic [7:0] cfg_rdata_o,
  input wire logic [15:0] io_addr_i,
  input wire logic io_rd_i,
  input wire logic io_wr_i,
  input wire ldir_pkg::ldir_unit_t unit_i,
  input wire logic [4:0] unit_irq_req_i,
  output ldir_pkg::ldir_sel_t sel_o,
  output logic [4:0] dev_active_o,
  output logic [4:0] base_valid_o,
  output logic [15:1] irq_line_o,
  output logic [15:1] irq_oe_o
);
  localparam logic [39:0] LDN_CODES = {`LDIR_LDN_KEYB, `LDIR_LDN_SER2, `LDIR_LDN_SER1,
    `LDIR_LDN_PAR, `LDIR_LDN_FLOPPY};

  logic [7:0] rdata_r;
  logic [4:0] valid_r;
  ldir_pkg::ldir_sel_t sel_r;
  ldir_pkg::ldir_sel_t sel_nxt;
  logic [7:0] rd_mux;
  wire [4:0] ldn_hit;
  wire [4:0] base_ok;
  wire [4:0] act_w;
  wire [15:0] base_w [5];
  wire [3:0] lvl_w [5];
  wire [7:0] rd_part [5];

  // configuration port is only reachable in configuration state
  wire cfg_we = cfg_wr_i & cfg_mode_i; // R15
  wire cfg_re = cfg_rd_i & cfg_mode_i; // R15
  wire idx_act = cfg_index_i == `LDIR_IDX_ACT;
  wire idx_hi = cfg_index_i == `LDIR_IDX_BASE_HI;
  wire idx_lo = cfg_index_i == `LDIR_IDX_BASE_LO;
  wire idx_irq = cfg_index_i == `LDIR_IDX_IRQ;

  genvar gi;
  generate
    for (gi = 0; gi < `LDIR_NDEV; gi++) begin : g_dev
      localparam bit RELOC = (gi != `LDIR_DEV_KEYB);
      logic act_r;
      logic [15:0] base_r;
      logic [3:0] lvl_r;
      wire we = cfg_we & ldn_hit[gi];
      assign ldn_hit[gi] = ldn_i == LDN_CODES[8*gi +: 8];
      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          act_r <= 1'b0;
          base_r <= 16'h0000;
          lvl_r <= `LDIR_LVL_NONE;
        end else begin
          if (we && idx_act) act_r <= cfg_wdata_i[0]; // R13
          if (we && idx_hi && RELOC) base_r[15:8] <= cfg_wdata_i; // R12
          if (we && idx_lo && RELOC) base_r[7:0] <= cfg_wdata_i; // R12
          if (we && idx_irq) lvl_r <= cfg_wdata_i[3:0]; // R6
        end
      end
      assign act_w[gi] = act_r;
      assign base_w[gi] = base_r;
      assign lvl_w[gi] = lvl_r;
      // second base pair and unused indices read zero
      assign rd_part[gi] = !ldn_hit[gi] ? 8'h00 :
        idx_act ? {7'h00, act_r} :
        idx_hi ? base_r[15:8] :
        idx_lo ? base_r[7:0] :
        idx_irq ? {4'h0, lvl_r} : 8'h00;
      if (gi == `LDIR_DEV_KEYB) begin : g_fixed
        assign base_ok[gi] = 1'b1; // R4
      end else if (gi == `LDIR_DEV_PAR) begin : g_par
        assign base_ok[gi] = base_r >= `LDIR_BASE_MIN && base_r <= `LDIR_BASE_MAX4 &&
          base_r[1:0] == 2'h0; // R2
      end else begin : g_oct
        assign base_ok[gi] = base_r >= `LDIR_BASE_MIN && base_r <= `LDIR_BASE_MAX8 &&
          base_r[2:0] == 3'h0; // R1
      end
    end
  endgenerate

  always_comb begin
    rd_mux = 8'h00;
    for (int i = 0; i < `LDIR_NDEV; i++) begin
      rd_mux = rd_mux | rd_part[i];
    end
  end

  // i/o decode on the low twelve address bits
  wire [11:0] a12 = io_addr_i[11:0]; // R5
  wire io_stb = io_rd_i | io_wr_i;
  wire [4:0] live = act_w & base_ok; // R14
  wire [11:0] fb = base_w[`LDIR_DEV_FLOPPY][11:0];
  wire [11:0] pb = base_w[`LDIR_DEV_PAR][11:0];
  wire [11:0] s1b = base_w[`LDIR_DEV_SER1][11:0];
  wire [11:0] s2b = base_w[`LDIR_DEV_SER2][11:0];
  wire epp_ok = pb[2:0] == 3'h0; // R2
  wire [11:0] ext_b = 12'(pb + `LDIR_EXT_OFS); // R3
  wire fl_hit = live[`LDIR_DEV_FLOPPY] && a12[11:3] == fb[11:3] &&
    a12[2:0] != `LDIR_FLOPPY_HOLE; // R1
  wire pp_std = live[`LDIR_DEV_PAR] && a12[11:2] == pb[11:2] &&
    a12[1:0] < `LDIR_PAR_STD_END; // R2
  wire pp_epp = live[`LDIR_DEV_PAR] && epp_ok && a12[11:3] == pb[11:3] &&
    a12[2:0] >= `LDIR_EPP_FIRST; // R2
  wire pp_ext = live[`LDIR_DEV_PAR] && a12[11:2] == ext_b[11:2] &&
    a12[1:0] <= `LDIR_EXT_LAST; // R3
  wire s1_hit = live[`LDIR_DEV_SER1] && a12[11:3] == s1b[11:3];
  wire s2_hit = live[`LDIR_DEV_SER2] && a12[11:3] == s2b[11:3];
  wire kb_hit = live[`LDIR_DEV_KEYB] && (a12 == `LDIR_KEYB_DATA || a12 == `LDIR_KEYB_CMD); // R4

  always_comb begin
    sel_nxt = '0;
    sel_nxt.floppy_cs = io_stb & fl_hit;
    sel_nxt.floppy_ofs = a12[2:0];
    sel_nxt.par_cs = io_stb & (pp_std | pp_epp);
    sel_nxt.par_ofs = epp_ok ? a12[2:0] : {1'b0, a12[1:0]};
    sel_nxt.par_ext_cs = io_stb & pp_ext;
    sel_nxt.par_ext_ofs = a12[1:0];
    sel_nxt.ser_cs = {io_stb & s2_hit, io_stb & s1_hit};
    sel_nxt.ser_ofs = a12[2:0];
    sel_nxt.keyb_cs = io_stb & kb_hit;
    sel_nxt.keyb_cmd = a12 == `LDIR_KEYB_CMD;
    sel_nxt.rd = io_rd_i;
    sel_nxt.wr = io_wr_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sel_r <= '0;
      rdata_r <= 8'h00;
      valid_r <= 5'h00;
    end else begin
      sel_r <= sel_nxt;
      valid_r <= base_ok;
      if (cfg_re) rdata_r <= rd_mux;
    end
  end

  // interrupt qualification per device
  wire [2:0] ecr = unit_i.ecr_mode;
  wire ecp_mode = ecr == `LDIR_ECR_FIFO || ecr == `LDIR_ECR_ECP || ecr == `LDIR_ECR_TEST;
  wire par_inv = ecp_mode || ecr == `LDIR_ECR_EPP; // R7
  wire [4:0] irq_en;
  assign irq_en[`LDIR_DEV_FLOPPY] = live[`LDIR_DEV_FLOPPY] & unit_i.floppy_dma_irq_enable; // R8
  assign irq_en[`LDIR_DEV_PAR] = live[`LDIR_DEV_PAR] & unit_i.port_interrupt_enable &
    ~(ecp_mode & unit_i.service_interrupt_mask); // R9
  assign irq_en[`LDIR_DEV_SER1] = live[`LDIR_DEV_SER1] & (|unit_i.uart_ier0) &
    unit_i.aux_output_two[0]; // R10
  assign irq_en[`LDIR_DEV_SER2] = live[`LDIR_DEV_SER2] & (|unit_i.uart_ier1) &
    unit_i.aux_output_two[1]; // R10
  assign irq_en[`LDIR_DEV_KEYB] = live[`LDIR_DEV_KEYB];
  wire [4:0] req_pol = unit_irq_req_i ^ {3'h0, par_inv, 1'b0}; // R7
  wire [19:0] lvl_flat = {lvl_w[4], lvl_w[3], lvl_w[2], lvl_w[1], lvl_w[0]};

  ldir_irq_route u_route (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .lvl_i(lvl_flat),
    .en_i(irq_en),
    .req_i(req_pol),
    .line_o(irq_line_o),
    .oe_o(irq_oe_o)
  );

  assign cfg_rdata_o = rdata_r;
  assign sel_o = sel_r;
  assign dev_active_o = act_w;
  assign base_valid_o = valid_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_floppy_hole: assert property (io_stb && a12[2:0] == 3'h6 |=> !sel_r.floppy_cs) // R1
    else $error("floppy offset six decoded");
  a_epp_alignment: assert property (
    io_stb && !epp_ok && a12[1:0] == 2'h3 |=> !sel_r.par_cs) // R2
    else $error("epp offset decoded on 4-byte base");
  a_ext_offset: assert property (
    io_stb && live[1] && a12 == {ext_b[11:2], 2'h2} |=> sel_r.par_ext_cs &&
    sel_r.par_ext_ofs == 2'h2) // R3
    else $error("extended control register not decoded");
  a_keyb_fixed: assert property (
    io_stb && act_w[4] && a12 == 12'h064 |=> sel_r.keyb_cs && sel_r.keyb_cmd) // R4
    else $error("keyboard command port not decoded");
  a_high_bits_ignored: assert property (
    io_stb && live[0] && a12 == fb |=> sel_r.floppy_cs && sel_r.floppy_ofs == 3'h0) // R5
    else $error("floppy base not decoded");
  a_level_upper_zero: assert property (cfg_re && idx_irq |=> cfg_rdata_o[7:4] == 4'h0) // R6
    else $error("level select upper bits not zero");
  a_floppy_gate: assert property (!unit_i.floppy_dma_irq_enable |-> !irq_en[0]) // R8
    else $error("floppy irq enabled without dma enable");
  a_par_service: assert property (ecp_mode && unit_i.service_interrupt_mask |-> !irq_en[1]) // R9
    else $error("parallel irq enabled while service masked");
  a_serial_gate: assert property (!unit_i.aux_output_two[0] |-> !irq_en[2]) // R10
    else $error("serial irq enabled without aux output two");
  a_par_enable_gate: assert property (!unit_i.port_interrupt_enable |-> !irq_en[1]) // R9
    else $error("parallel irq enabled without port enable");
  a_uart_enable_gate: assert property (unit_i.uart_ier0 == 4'h0 |-> !irq_en[2]) // R10
    else $error("serial irq enabled with no uart enable bit");
  a_serial2_gate: assert property (!unit_i.aux_output_two[1] |-> !irq_en[3]) // R10
    else $error("second serial irq enabled without aux output two");
  a_rdata_locked: assert property (!cfg_mode_i |=> $stable(cfg_rdata_o)) // R15
    else $error("read data changed outside configuration state");
  a_activate_link: assert property (
    cfg_we && ldn_hit[0] && idx_act |=> dev_active_o[0] == $past(cfg_wdata_i[0])) // R13
    else $error("activate bit not written");
  a_invalid_silent: assert property (!live[0] |=> !sel_r.floppy_cs) // R14
    else $error("access decoded for invalid base");
  a_cfg_locked: assert property (!cfg_mode_i |=> $stable(lvl_flat)) // R15
    else $error("level changed outside configuration state");
  c_floppy_access: cover property (sel_r.floppy_cs && sel_r.wr);
  c_epp_access: cover property (sel_r.par_cs && sel_r.par_ofs == 3'h4);
  c_serial_irq: cover property (irq_en[2] && lvl_w[2] != 4'h0);
endmodule

//--- bench/ldir_unit_model.sv
// far-side unit model: unit enable levels and raw interrupt requests
`timescale 1ns/100ps
module ldir_unit_model (
  input wire logic clk_i,
  output ldir_pkg::ldir_unit_t unit_o,
  output logic [4:0] req_o
);
  initial begin
    unit_o = '0;
    req_o = 5'h00;
  end
  // levels change only after a falling edge
  task automatic drive(input ldir_pkg::ldir_unit_t u, input logic [4:0] r);
    @(negedge clk_i);
    unit_o = u;
    req_o = r;
  endtask
endmodule

//--- bench/tb.sv
// testbench for the logical device decode and irq steering
`timescale 1ns/100ps
`include "ldir_regs.svh"
module tb;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cfg_mode = 1'b1;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic io_rd = 1'b0;
  logic io_wr = 1'b0;
  logic [7:0] ldn = 8'h00;
  logic [7:0] idx = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [15:0] addr = 16'h0000;
  ldir_pkg::ldir_unit_t unit;
  ldir_pkg::ldir_sel_t sel;
  logic [4:0] req;
  logic [4:0] act;
  logic [4:0] bval;
  logic [15:1] irq;
  logic [15:1] oe;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;

  always #4 clk_i = ~clk_i;

  ldir_unit_model um (.clk_i(clk_i), .unit_o(unit), .req_o(req));

  ldir_top dut_u (.clk_i(clk_i), .srst_i(srst_i), .cfg_mode_i(cfg_mode), .ldn_i(ldn),
    .cfg_index_i(idx), .cfg_wdata_i(wdata), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
    .cfg_rdata_o(rdata), .io_addr_i(addr), .io_rd_i(io_rd), .io_wr_i(io_wr),
    .unit_i(unit), .unit_irq_req_i(req), .sel_o(sel), .dev_active_o(act),
    .base_valid_o(bval), .irq_line_o(irq), .irq_oe_o(oe));

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic cfgw(input logic [7:0] l, input logic [7:0] i, input logic [7:0] d);
    @(negedge clk_i);
    ldn = l;
    idx = i;
    wdata = d;
    cfg_wr = 1'b1;
    @(negedge clk_i);
    cfg_wr = 1'b0;
  endtask

  task automatic cfgr(input logic [7:0] l, input logic [7:0] i, input logic [7:0] e);
    @(negedge clk_i);
    ldn = l;
    idx = i;
    cfg_rd = 1'b1;
    @(negedge clk_i);
    cfg_rd = 1'b0;
    chk(16'(rdata), 16'(e));
  endtask

  task automatic iocyc(input logic [15:0] a, input logic w);
    @(negedge clk_i);
    addr = a;
    io_rd = ~w;
    io_wr = w;
    @(negedge clk_i);
    io_rd = 1'b0;
    io_wr = 1'b0;
  endtask

  task automatic setup(input logic [7:0] l, input logic [15:0] b, input logic [7:0] lv);
    cfgw(l, `LDIR_IDX_BASE_HI, b[15:8]);
    cfgw(l, `LDIR_IDX_BASE_LO, b[7:0]);
    cfgw(l, `LDIR_IDX_IRQ, lv);
    cfgw(l, `LDIR_IDX_ACT, 8'h01);
    @(negedge clk_i);
  endtask

  task automatic wait2();
    repeat (2) @(negedge clk_i);
  endtask

  function automatic ldir_pkg::ldir_unit_t uv(logic d, logic p, logic s, logic [2:0] m,
    logic [3:0] i, logic [1:0] o);
    return {d, p, s, m, i, 4'h0, o};
  endfunction

  initial begin
    repeat (20) @(negedge clk_i);
    srst_i = 1'b0;
    cfgr(8'h00, `LDIR_IDX_BASE_HI, 8'h00);
    cfgr(8'h00, `LDIR_IDX_IRQ, 8'h00);
    setup(`LDIR_LDN_FLOPPY, 16'h01f0, 8'h76);
    cfgr(8'h00, `LDIR_IDX_BASE_HI, 8'h01);
    cfgr(8'h00, `LDIR_IDX_BASE_LO, 8'hf0);
    cfgr(8'h00, `LDIR_IDX_IRQ, 8'h06);
    cfgr(8'h00, `LDIR_IDX_ACT, 8'h01);
    chk(16'(act[0]), 16'h0001);
    chk(16'(bval[0]), 16'h0001);
    iocyc(16'hf1f2, 1'b0);
    chk(16'({sel.floppy_cs, sel.floppy_ofs, sel.rd}), 16'h0015);
    iocyc(16'h01f6, 1'b0);
    chk(16'(sel.floppy_cs), 16'h0000);
    iocyc(16'h01f7, 1'b0);
    chk(16'({sel.floppy_cs, sel.floppy_ofs}), 16'h000f);
    um.drive(uv(1'b1, 1'b0, 1'b0, 3'h0, 4'h0, 2'h0), 5'h01);
    wait2();
    chk(16'(oe), 16'h0020);
    chk(16'(irq & oe), 16'h0020);
    um.drive(uv(1'b0, 1'b0, 1'b0, 3'h0, 4'h0, 2'h0), 5'h01);
    wait2();
    chk(16'(oe), 16'h0000);
    setup(`LDIR_LDN_SER1, 16'h03f8, 8'h04);
    iocyc(16'h83fa, 1'b0);
    chk(16'({sel.ser_cs, sel.ser_ofs}), 16'h000a);
    um.drive(uv(1'b0, 1'b0, 1'b0, 3'h0, 4'h2, 2'h1), 5'h04);
    wait2();
    chk(16'(oe), 16'h0008);
    um.drive(uv(1'b0, 1'b0, 1'b0, 3'h0, 4'h2, 2'h0), 5'h04);
    wait2();
    chk(16'(oe), 16'h0000);
    setup(`LDIR_LDN_PAR, 16'h0384, 8'h07);
    iocyc(16'h0387, 1'b0);
    chk(16'(sel.par_cs), 16'h0000);
    iocyc(16'h0386, 1'b0);
    chk(16'({sel.par_cs, sel.par_ofs}), 16'h000a);
    setup(`LDIR_LDN_PAR, 16'h0378, 8'h07);
    iocyc(16'h037b, 1'b0);
    chk(16'({sel.par_cs, sel.par_ofs}), 16'h000b);
    iocyc(16'h037c, 1'b1);
    chk(16'({sel.par_cs, sel.par_ofs, sel.wr}), 16'h0019);
    iocyc(16'h077a, 1'b0);
    chk(16'({sel.par_ext_cs, sel.par_ext_ofs}), 16'h0006);
    um.drive(uv(1'b0, 1'b1, 1'b1, 3'h3, 4'h0, 2'h0), 5'h00);
    wait2();
    chk(16'(oe), 16'h0000);
    um.drive(uv(1'b0, 1'b1, 1'b0, 3'h3, 4'h0, 2'h0), 5'h00);
    wait2();
    chk(16'(oe), 16'h0040);
    chk(16'(irq & oe), 16'h0040);
    um.drive(uv(1'b0, 1'b1, 1'b1, 3'h4, 4'h0, 2'h0), 5'h00);
    wait2();
    chk(16'(oe), 16'h0040);
    chk(16'(irq & oe), 16'h0040);
    um.drive(uv(1'b0, 1'b1, 1'b0, 3'h0, 4'h0, 2'h0), 5'h00);
    wait2();
    chk(16'(irq & oe), 16'h0000);
    setup(`LDIR_LDN_KEYB, 16'h0000, 8'h00);
    iocyc(16'h0064, 1'b1);
    chk(16'({sel.keyb_cs, sel.keyb_cmd, sel.wr}), 16'h0007);
    iocyc(16'h0060, 1'b0);
    chk(16'({sel.keyb_cs, sel.keyb_cmd, sel.wr}), 16'h0004);
    setup(`LDIR_LDN_FLOPPY, 16'h00f0, 8'h06);
    chk(16'(bval[0]), 16'h0000);
    iocyc(16'h00f2, 1'b0);
    chk(16'(sel.floppy_cs), 16'h0000);
    cfgw(8'h00, `LDIR_IDX_BASE_HI, 8'h01);
    cfgw(8'h00, `LDIR_IDX_BASE_LO, 8'hf4);
    @(negedge clk_i);
    chk(16'(bval[0]), 16'h0000);
    cfgw(8'h00, `LDIR_IDX_ACT, 8'h00);
    @(negedge clk_i);
    chk(16'(act[0]), 16'h0000);
    cfg_mode = 1'b0;
    cfgw(8'h00, `LDIR_IDX_IRQ, 8'h09);
    cfg_mode = 1'b1;
    cfgr(8'h00, `LDIR_IDX_IRQ, 8'h06);
    test_done();
  end
endmodule
